// ---- prsi_map.svh ----
// Register map, field positions, reset values and timing counts
`ifndef PRSI_MAP_SVH
`define PRSI_MAP_SVH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define PRSI_IDX_BASIC_MODE_CONTROL  5'h00
`define PRSI_IDX_BASIC_MODE_STATUS   5'h01
`define PRSI_IDX_MULTI_LED_CONFIG    5'h18
`define PRSI_IDX_STRAP_STATUS        5'h19
`define PRSI_IDX_SOFT_RESET_CONTROL  5'h1F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRSI_BMC_MGMT_RESET     15
`define PRSI_BMC_AN_ENABLE      12
`define PRSI_BMC_AN_RESTART     8
`define PRSI_BMS_AN_COMPLETE    5
`define PRSI_BMS_LINK_STATUS    2
`define PRSI_SRC_SOFT_RESET     15
`define PRSI_SRC_DIGITAL_RESET  14
`define PRSI_MLC_COL_DISABLE    0
`define PRSI_MLC_ACT_TO_COL     1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRSI_BMC_RESET          16'h1000
`define PRSI_BMS_FIXED          16'h7809
`define PRSI_MLC_RESET          2'h0
`define PRSI_ADDR_STRAP_DEFAULT 5'h01
`define PRSI_MODE_STRAP_DEFAULT 1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define PRSI_CLK_PERIOD_NS      10
`define PRSI_RST_PULSE_MIN_NS   1000
`define PRSI_RST_DONE_US        200
`define PRSI_RST_PULSE_CYC      ((`PRSI_RST_PULSE_MIN_NS + `PRSI_CLK_PERIOD_NS - 1) / `PRSI_CLK_PERIOD_NS)
`define PRSI_RST_DONE_CYC       ((`PRSI_RST_DONE_US * 1000) / `PRSI_CLK_PERIOD_NS)

`endif

// ---- prsi_pkg.sv ----
// Types shared by the reset and bring-up logic
package prsi_pkg;

	typedef enum logic [1:0] {
		PRSI_SEQ_RUN    = 2'b00,
		PRSI_SEQ_PULSE  = 2'b01,
		PRSI_SEQ_RELAT  = 2'b10,
		PRSI_SEQ_BUSY   = 2'b11
	} prsi_seq_t;

	typedef enum logic [1:0] {
		PRSI_AN_IDLE    = 2'b00,
		PRSI_AN_RUN     = 2'b01,
		PRSI_AN_DONE    = 2'b10
	} prsi_an_t;

endpackage

// ---- prsi_reset_seq.sv ----
// Hardware reset pulse qualifier and internal reset completion timer
`include "prsi_map.svh"

module prsi_reset_seq #(
	parameter int PULSE_CYC = `PRSI_RST_PULSE_CYC,
	parameter int DONE_CYC  = `PRSI_RST_DONE_CYC
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Reset pin and soft request
	input  wire logic                hw_reset_pin_n,
	input  wire logic                soft_req,
	// Sequencer outputs
	output prsi_pkg::prsi_seq_t      seq_state,
	output logic                     core_clear,
	output logic                     relatch,
	output logic                     busy
);
	import prsi_pkg::*;

	prsi_seq_t    state_reg;
	prsi_seq_t    state_next;
	logic [31:0]  cnt_reg;
	logic [31:0]  cnt_next;

	wire pulse_ok = (cnt_reg >= 32'(PULSE_CYC - 1));
	wire done_ok  = (cnt_reg >= 32'(DONE_CYC - 1));

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 32'h1;
		case (state_reg)
			PRSI_SEQ_RUN: begin
				cnt_next = 32'h0;
				if (!hw_reset_pin_n) begin
					state_next = PRSI_SEQ_PULSE;
				end else if (soft_req) begin
					state_next = PRSI_SEQ_BUSY;
				end
			end
			PRSI_SEQ_PULSE: begin
				if (hw_reset_pin_n) begin
					// Short glitch is ignored; a full-width pulse resets all
					state_next = pulse_ok ? PRSI_SEQ_RELAT : PRSI_SEQ_RUN;
					cnt_next   = 32'h0;
				end else if (pulse_ok) begin
					cnt_next = cnt_reg;
				end
			end
			PRSI_SEQ_RELAT: begin
				state_next = PRSI_SEQ_BUSY;
				cnt_next   = 32'h0;
			end
			PRSI_SEQ_BUSY: begin
				if (!hw_reset_pin_n) begin
					state_next = PRSI_SEQ_PULSE;
					cnt_next   = 32'h0;
				end else if (done_ok) begin
					state_next = PRSI_SEQ_RUN;
					cnt_next   = 32'h0;
				end
			end
			default: begin
				state_next = PRSI_SEQ_RUN;
				cnt_next   = 32'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Power-up follows the same path as a pin reset
			state_reg <= PRSI_SEQ_RELAT;
			cnt_reg   <= 32'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign seq_state  = state_reg;
	assign core_clear = (state_reg == PRSI_SEQ_RELAT) ||
	                    ((state_reg == PRSI_SEQ_PULSE) && pulse_ok);
	assign relatch    = (state_reg == PRSI_SEQ_RELAT);
	assign busy       = (state_reg != PRSI_SEQ_RUN);

endmodule

// ---- prsi_phy_init.sv ----
// Reset, strap latch, management registers and LED routing of the transceiver
// Function
// - Reset pin low one microsecond resets all
// - Hardware reset restores defaults, relatches straps
// - Internal reset completes about 200 microseconds later
// - Autoneg complete bit set when negotiation ends
// - Receive-valid strap selects MII or RMII
// - Five address straps latched at hardware reset
// - Link output steady on, blinks on activity
// - Activity moves to collision pin if disabled and routing bit set
// - Address straps default to one, full range
//
// Chosen here: the Wishbone slave port.
`include "prsi_map.svh"

module prsi_phy_init #(
	parameter int ADR_W     = 8,
	parameter int DONE_CYC  = `PRSI_RST_DONE_CYC,
	parameter int AN_CYC    = 1000,
	parameter int BLINK_CYC = 2000
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// Hardware reset pin and straps
	input  wire logic              hw_reset_pin_n,
	input  wire logic              mgmt_addr_strap_bit0,
	input  wire logic [3:0]        rxd_strap,
	input  wire logic              rx_dv_strap,
	// Line status
	input  wire logic              link_up,
	input  wire logic              activity,
	input  wire logic              collision,
	// Pins and status
	output logic                   link_indicator_output,
	output logic                   col_o,
	output logic                   col_oe,
	output logic [4:0]             mgmt_addr,
	output logic                   rmii_mode,
	output logic                   reset_busy
);
	import prsi_pkg::*;

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	logic       core_clear;
	logic       relatch;
	logic       soft_req;

	prsi_reset_seq #(
		.PULSE_CYC (`PRSI_RST_PULSE_CYC),
		.DONE_CYC  (DONE_CYC)
	) u_seq (
		.clk            (clk),
		.rst_n          (rst_n),
		.hw_reset_pin_n (hw_reset_pin_n),
		.soft_req       (soft_req),
		.seq_state      (),
		.core_clear     (core_clear),
		.relatch        (relatch),
		.busy           (reset_busy)
	);

	// ----------------------------------------
	// Strap latch
	// ----------------------------------------
	logic [4:0] addr_reg;
	logic       mode_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= `PRSI_ADDR_STRAP_DEFAULT;
			mode_reg <= `PRSI_MODE_STRAP_DEFAULT;
		end else if (relatch) begin
			addr_reg <= {rxd_strap, mgmt_addr_strap_bit0};
			mode_reg <= rx_dv_strap;
		end
	end

	assign mgmt_addr = addr_reg;
	assign rmii_mode = mode_reg;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic        ack_reg;
	logic [31:0] rdat_reg;

	wire [4:0] idx      = wb_adr_i[6:2];
	wire       hi_zero  = (wb_adr_i[ADR_W-1:7] == '0) && (wb_adr_i[1:0] == 2'h0);
	wire       req      = wb_cyc_i && wb_stb_i && !ack_reg;
	wire       wr       = req && wb_we_i && !reset_busy;
	wire       hit_bmc  = hi_zero && (idx == `PRSI_IDX_BASIC_MODE_CONTROL);
	wire       hit_bms  = hi_zero && (idx == `PRSI_IDX_BASIC_MODE_STATUS);
	wire       hit_mlc  = hi_zero && (idx == `PRSI_IDX_MULTI_LED_CONFIG);
	wire       hit_strp = hi_zero && (idx == `PRSI_IDX_STRAP_STATUS);
	wire       hit_src  = hi_zero && (idx == `PRSI_IDX_SOFT_RESET_CONTROL);
	wire [15:0] lane_m  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [15:0] wdat    = wb_dat_i[15:0];

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] bmc_reg;
	logic [1:0]  mlc_reg;
	logic        an_cmpl_reg;
	prsi_an_t    an_reg;
	prsi_an_t    an_next;
	logic [31:0] an_cnt_reg;

	wire [15:0] bmc_wr   = (bmc_reg & ~lane_m) | (wdat & lane_m);
	wire        bmc_we   = wr && hit_bmc;
	wire        src_we   = wr && hit_src;
	wire        mgmt_rst = bmc_we && bmc_wr[`PRSI_BMC_MGMT_RESET];
	wire        dig_rst  = src_we && wb_sel_i[1] &&
	                       (wdat[`PRSI_SRC_SOFT_RESET] || wdat[`PRSI_SRC_DIGITAL_RESET]);
	wire        clr_all  = core_clear || mgmt_rst || dig_rst;
	wire        an_start = bmc_we && bmc_wr[`PRSI_BMC_AN_ENABLE] &&
	                       bmc_wr[`PRSI_BMC_AN_RESTART];
	wire        an_fin   = (an_reg == PRSI_AN_RUN) && link_up &&
	                       (an_cnt_reg >= 32'(AN_CYC - 1));

	// Digital reset reruns the internal completion wait
	assign soft_req = dig_rst;

	always_comb begin
		an_next = an_reg;
		case (an_reg)
			PRSI_AN_IDLE: an_next = an_start ? PRSI_AN_RUN : PRSI_AN_IDLE;
			PRSI_AN_RUN:  an_next = an_fin ? PRSI_AN_DONE : PRSI_AN_RUN;
			PRSI_AN_DONE: an_next = an_start ? PRSI_AN_RUN : PRSI_AN_DONE;
			default:      an_next = PRSI_AN_IDLE;
		endcase
		if (!link_up && (an_reg == PRSI_AN_DONE)) begin
			an_next = PRSI_AN_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bmc_reg <= `PRSI_BMC_RESET;
			mlc_reg <= `PRSI_MLC_RESET;
		end else if (clr_all) begin
			bmc_reg <= `PRSI_BMC_RESET;
			mlc_reg <= `PRSI_MLC_RESET;
		end else begin
			if (bmc_we) begin
				// Restart and reset bits self-clear
				bmc_reg <= bmc_wr & ~(16'h1 << `PRSI_BMC_AN_RESTART);
			end
			if (wr && hit_mlc && wb_sel_i[0]) begin
				mlc_reg <= wdat[1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			an_reg      <= PRSI_AN_IDLE;
			an_cnt_reg  <= 32'h0;
			an_cmpl_reg <= 1'b0;
		end else if (clr_all) begin
			an_reg      <= PRSI_AN_IDLE;
			an_cnt_reg  <= 32'h0;
			an_cmpl_reg <= 1'b0;
		end else begin
			an_reg      <= an_next;
			an_cnt_reg  <= (an_reg == PRSI_AN_RUN && !an_start) ? an_cnt_reg + 32'h1 : 32'h0;
			// Completion wins over a restart in the same cycle
			if (an_fin) begin
				an_cmpl_reg <= 1'b1;
			end else if (an_start || !link_up) begin
				an_cmpl_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------
	wire [15:0] bms_val  = `PRSI_BMS_FIXED |
	                       (16'(an_cmpl_reg) << `PRSI_BMS_AN_COMPLETE) |
	                       (16'(link_up) << `PRSI_BMS_LINK_STATUS);
	wire [15:0] strp_val = {8'h00, reset_busy, mode_reg, 1'b0, addr_reg};
	wire [15:0] rd_val   = hit_bmc  ? bmc_reg :
	                       hit_bms  ? bms_val :
	                       hit_mlc  ? {14'h0000, mlc_reg} :
	                       hit_strp ? strp_val :
	                       16'h0000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg  <= req;
			rdat_reg <= (req && !wb_we_i) ? {16'h0000, rd_val} : 32'h00000000;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// ----------------------------------------
	// LED routing
	// ----------------------------------------
	logic [31:0] blink_reg;
	logic        led_reg;
	logic        col_reg;

	wire act_blink = (blink_reg != 32'h0) && (blink_reg >= 32'(BLINK_CYC / 2));
	wire act_to_col = mlc_reg[`PRSI_MLC_ACT_TO_COL] && mlc_reg[`PRSI_MLC_COL_DISABLE];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_reg <= 32'h0;
			led_reg   <= 1'b0;
			col_reg   <= 1'b0;
		end else begin
			if (activity && blink_reg == 32'h0) begin
				blink_reg <= 32'(BLINK_CYC);
			end else if (blink_reg != 32'h0) begin
				blink_reg <= blink_reg - 32'h1;
			end
			led_reg <= link_up && !(act_blink && !act_to_col);
			col_reg <= act_to_col ? act_blink :
			           (!mlc_reg[`PRSI_MLC_COL_DISABLE] && collision);
		end
	end

	assign link_indicator_output = led_reg && !reset_busy;
	assign col_o  = col_reg;
	// Collision pin stays an input while straps may be sampled
	assign col_oe = !reset_busy;

endmodule

// ---- prsi_phy_init_asserts.sv ----
// Port-level checks of the transceiver reset and bring-up logic
module prsi_phy_init_asserts #(
	parameter int ADR_W    = 8,
	parameter int DONE_CYC = 200
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       hw_reset_pin_n,
	input wire logic       mgmt_addr_strap_bit0,
	input wire logic [3:0] rxd_strap,
	input wire logic       rx_dv_strap,
	input wire logic       link_up,
	input wire logic       link_indicator_output,
	input wire logic       col_oe,
	input wire logic [4:0] mgmt_addr,
	input wire logic       rmii_mode,
	input wire logic       reset_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BUSY_LO = DONE_CYC - 10;
	logic [7:0] low_cnt;

	// ----
	// Length of the current reset pin pulse
	// ----
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			low_cnt <= 8'h00;
		else if (hw_reset_pin_n)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hFF)
			low_cnt <= low_cnt + 8'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	chk_busy_on_pin: assert property (!hw_reset_pin_n |=> reset_busy)
		else $error("reset pin low without busy");
	chk_busy_window: assert property ($rose(hw_reset_pin_n) && low_cnt >= 8'h64 |->
		##BUSY_LO reset_busy ##[1:20] !reset_busy)
		else $error("internal reset time wrong");
	chk_strap_relatch: assert property ($rose(hw_reset_pin_n) && low_cnt >= 8'h64 |->
		##3 mgmt_addr == {rxd_strap, mgmt_addr_strap_bit0} && rmii_mode == rx_dv_strap)
		else $error("straps not relatched");
	chk_led_no_link: assert property (!link_up |=> !link_indicator_output)
		else $error("link output on without link");
	chk_led_busy: assert property (reset_busy && $past(reset_busy) |-> !link_indicator_output)
		else $error("link output on during reset");
	chk_col_oe_busy: assert property (reset_busy && $past(reset_busy) |-> !col_oe)
		else $error("collision pin driven during reset");
endmodule

// ---- prsi_mac_model.sv ----
// Management master model: bus cycles and the bring-up sequence
module prsi_mac_model #(
	parameter int WAIT_CYC = 250
) (
	// Clock
	input  wire logic        clk,
	// Wishbone master
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat_w,
	input  wire logic [31:0] dat_r,
	input  wire logic        ack
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat_w = 32'h0;
	end

	task automatic xfer(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
		output logic [15:0] rd);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {1'b0, idx, 2'b00};
		sel <= 4'h3;
		dat_w <= {16'h0000, wd};
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_r[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic bring_up(output logic [15:0] st);
		logic [15:0] d;
		xfer(1'b1, 5'h00, 16'h8000, d);
		xfer(1'b1, 5'h1F, 16'hC000, d);
		repeat (WAIT_CYC) @(posedge clk);
		xfer(1'b1, 5'h00, 16'h1100, d);
		do xfer(1'b0, 5'h01, 16'h0000, st); while (st[5] !== 1'b1);
	endtask
endmodule

// ---- test_prsi_phy_init.sv ----
// Self-checking bench for the transceiver reset and bring-up logic
module test_prsi_phy_init;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, cyc, stb, we, ack, pin_n, a0, rxdv, link_up, act, coll;
	logic        led, col_o, col_oe, rmii, busy;
	logic [7:0]  adr;
	logic [3:0]  sel, rxd;
	logic [31:0] wdat, rdat;
	logic [4:0]  maddr;
	logic [15:0] d;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc_cnt = 0;
	int          off;
	int          col_on;

	prsi_mac_model #(.WAIT_CYC(250)) mac (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .dat_w(wdat), .dat_r(rdat), .ack(ack));
	prsi_phy_init #(.DONE_CYC(200), .AN_CYC(20), .BLINK_CYC(8)) uut (.clk(clk),
		.rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.hw_reset_pin_n(pin_n), .mgmt_addr_strap_bit0(a0), .rxd_strap(rxd),
		.rx_dv_strap(rxdv), .link_up(link_up), .activity(act), .collision(coll),
		.link_indicator_output(led), .col_o(col_o), .col_oe(col_oe), .mgmt_addr(maddr),
		.rmii_mode(rmii), .reset_busy(busy));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string what);
		mac.xfer(1'b0, idx, 16'h0000, d);
		check(what, d, exp);
	endtask

	task automatic wait_idle;
		while (busy !== 1'b0) @(posedge clk);
	endtask

	task automatic pulse(input int n);
		@(posedge clk);
		pin_n <= 1'b0;
		repeat (n) @(posedge clk);
		pin_n <= 1'b1;
		@(posedge clk);
		wait_idle();
	endtask

	// Count dark cycles of the link output after one activity event
	task automatic blink;
		@(posedge clk);
		act <= 1'b1;
		@(posedge clk);
		act <= 1'b0;
		off = 0;
		col_on = 0;
		repeat (12) begin
			@(posedge clk);
			if (led === 1'b0)
				off++;
			if (col_o === 1'b1)
				col_on++;
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	initial begin
		rst_n = 1'b0;
		pin_n = 1'b1;
		a0 = 1'b1;
		rxd = 4'h0;
		rxdv = 1'b0;
		link_up = 1'b0;
		act = 1'b0;
		coll = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wait_idle();
		rd(5'h00, 16'h1000, "control default");
		rd(5'h19, 16'h0001, "strap default");
		check("mode pin default", {15'h0000, rmii}, 16'h0000);
		rd(5'h01, 16'h7809, "status idle");
		rd(5'h02, 16'h0000, "unmapped read");
		$display("test defaults done");
		link_up <= 1'b1;
		mac.bring_up(d);
		check("status negotiated", d, 16'h782D);
		rd(5'h00, 16'h1000, "control after restart");
		$display("test bring-up done");
		mac.xfer(1'b1, 5'h00, 16'h0000, d);
		mac.xfer(1'b1, 5'h02, 16'h1234, d);
		mac.xfer(1'b1, 5'h01, 16'hFFFF, d);
		rd(5'h00, 16'h0000, "control written");
		pulse(99);
		rd(5'h00, 16'h0000, "control after short pulse");
		rxd <= 4'hF;
		a0 <= 1'b0;
		rxdv <= 1'b1;
		pulse(100);
		rd(5'h00, 16'h1000, "control after pin reset");
		rd(5'h01, 16'h780D, "status after pin reset");
		rd(5'h19, 16'h005E, "straps relatched");
		check("address pins", {11'h000, maddr}, 16'h001E);
		check("mode pin", {15'h0000, rmii}, 16'h0001);
		$display("test pin reset done");
		repeat (4) @(posedge clk);
		check("link steady", {15'h0000, led}, 16'h0001);
		blink();
		check("blink on link", {15'h0000, off != 0}, 16'h0001);
		mac.xfer(1'b1, 5'h18, 16'h0002, d);
		blink();
		check("route refused", {15'h0000, off != 0}, 16'h0001);
		check("collision idle", {15'h0000, col_on != 0}, 16'h0000);
		coll <= 1'b1;
		repeat (3) @(posedge clk);
		check("collision passed", {15'h0000, col_o}, 16'h0001);
		check("collision pin driven", {15'h0000, col_oe}, 16'h0001);
		mac.xfer(1'b1, 5'h18, 16'h0001, d);
		repeat (2) @(posedge clk);
		check("collision disabled", {15'h0000, col_o}, 16'h0000);
		coll <= 1'b0;
		mac.xfer(1'b1, 5'h18, 16'h0003, d);
		blink();
		check("route moved", {15'h0000, off != 0}, 16'h0000);
		check("activity on collision", {15'h0000, col_on != 0}, 16'h0001);
		$display("test indicator done");
		tally_and_finish();
	end
endmodule

bind prsi_phy_init prsi_phy_init_asserts #(.ADR_W(ADR_W), .DONE_CYC(DONE_CYC)) u_chk (
	.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .hw_reset_pin_n(hw_reset_pin_n),
	.mgmt_addr_strap_bit0(mgmt_addr_strap_bit0), .rxd_strap(rxd_strap),
	.rx_dv_strap(rx_dv_strap), .link_up(link_up),
	.link_indicator_output(link_indicator_output), .col_oe(col_oe),
	.mgmt_addr(mgmt_addr), .rmii_mode(rmii_mode), .reset_busy(reset_busy));
